// ===== logic/tasf_defines.svh
`ifndef TASF_DEFINES_SVH
`define TASF_DEFINES_SVH

// Register select codes on the host read port
`define TASF_SEL_WARN 1'h0
`define TASF_SEL_OVER 1'h1

// Channel numbering: 0 is the local sensor, 1 to 6 the remote diodes
`define TASF_CHAN_LOCAL 3'h0
`define TASF_CHAN_LAST 3'h6
`define TASF_CHAN_COUNT 7

// Warning flag position of the local channel
`define TASF_LOCAL_BIT 3'h6

// Remote channels that also carry an overtemperature limit
`define TASF_OVER_CH_A 3'h1
`define TASF_OVER_CH_B 3'h4
`define TASF_OVER_CH_C 3'h5
`define TASF_OVER_CH_D 3'h6

// Hysteresis below a limit before a trip is released, in degrees
`define TASF_HYST 9'h004

// Reset values of the status registers and output latches
`define TASF_WARN_RST 7'h00
`define TASF_OVER_RST 4'h0
`define TASF_BYTE_RST 8'h00

`endif

// ===== logic/tasf_pkg.sv
package tasf_pkg;

  // Measurement sequencer states
  typedef enum logic [1:0] {
    TASF_SEQ_PICK = 2'b00,
    TASF_SEQ_START = 2'b01,
    TASF_SEQ_WAIT = 2'b10
  } tasf_seq_t;

  // Channel number, 0 local and 1 to 6 remote
  typedef logic [2:0] tasf_chan_t;

  // One status register byte
  typedef logic [7:0] tasf_byte_t;

endpackage : tasf_pkg

// ===== logic/tasf_sync.sv
// Two flip-flop synchroniser for levels entering a clock domain
module tasf_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rstN,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  // First stage, read only by the second stage
  logic [WIDTH-1:0] meta_r;

  // Both stages shift on every edge
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule : tasf_sync

// ===== logic/tasf_status_flags.sv
// How it works
// - Local over warning limit sets flag bit 6
// - Remote n over warning limit sets bit n-1
// - Channels 1,4,5,6 overtemperature set bits 0,3,4,5
// - Open or supply-tied diode reports a fault
// - Sequencer skips faulted remote channels
// - Read of overtemp flags clears them only
// - Trip releases only four degrees below limit
// - Acked warning reasserts after next conversion
`include "tasf_defines.svh"

module tasf_status_flags (
  input wire logic clk_sys,
  input wire logic nrst,
  // Converter handshake, same clock domain
  output logic convStart,
  output tasf_pkg::tasf_chan_t convChan,
  input wire logic convDone,
  input wire logic [7:0] convTemp,
  // Limits and masks from the configuration registers
  input wire logic [6:0][7:0] warnLimit,
  input wire logic [3:0][7:0] overLimit,
  input wire logic [6:0] warnMask,
  input wire logic [3:0] overMask,
  input wire logic alertAck,
  // Remote diode pins, sensed as logic levels
  input wire logic [5:0] diode_anode_in,
  input wire logic [5:0] diode_cathode_in,
  output logic [5:0] diodeFault,
  // Open-drain outputs, pulled low while enabled
  output logic alertOut,
  output logic alertOutOe,
  output logic overtemp_out,
  output logic overtempOutOe,
  // Host read port on the serial engine clock
  input wire logic linkClk,
  input wire logic linkReadReq,
  input wire logic linkRegSel,
  output tasf_pkg::tasf_byte_t linkReadData,
  output logic linkReadValid,
  output logic linkBusy
);
  import tasf_pkg::*;

  // Flag bit of a channel in the warning register
  function automatic logic [2:0] flagBit(input tasf_chan_t chan);
    flagBit = (chan == `TASF_CHAN_LOCAL) ? `TASF_LOCAL_BIT : 3'(chan - 3'h1);
  endfunction : flagBit

  // Overtemperature slot of a channel; top bit marks a valid slot
  function automatic logic [2:0] overSlot(input tasf_chan_t chan);
    case (chan)
      `TASF_OVER_CH_A: overSlot = 3'h4;
      `TASF_OVER_CH_B: overSlot = 3'h5;
      `TASF_OVER_CH_C: overSlot = 3'h6;
      `TASF_OVER_CH_D: overSlot = 3'h7;
      default: overSlot = 3'h0;
    endcase
  endfunction : overSlot

  // Next channel after cur that is not faulted, local always healthy
  function automatic tasf_chan_t nextHealthy(input tasf_chan_t cur, input logic [5:0] flt);
    tasf_chan_t res;
    logic found;
    int cand;
    res = `TASF_CHAN_LOCAL;
    found = 1'b0;
    for (int k = 1; k <= `TASF_CHAN_COUNT; k++) begin
      cand = (int'(cur) + k) % `TASF_CHAN_COUNT;
      if (!found && (cand == 0 || !flt[cand-1])) begin
        res = 3'(cand);
        found = 1'b1;
      end
    end
    nextHealthy = res;
  endfunction : nextHealthy

  // Released trip test: temperature at least the hysteresis under the limit
  function automatic logic tripRelease(input logic [7:0] temp, input logic [7:0] lim);
    tripRelease = ({1'b0, temp} + `TASF_HYST) <= {1'b0, lim};
  endfunction : tripRelease

  // Reset synchroniser, system domain
  logic [1:0] rstPipe_r;
  logic rstN;

  // Release the reset through two flip-flops
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rstPipe_r <= 2'h0;
    end else begin
      rstPipe_r <= {rstPipe_r[0], 1'b1};
    end
  end
  assign rstN = rstPipe_r[1];

  // Diode pins pass two flip-flops before use
  logic [5:0] anodeSync;
  logic [5:0] cathodeSync;

  tasf_sync #(.WIDTH(12)) uPinSync (
    .clk(clk_sys),
    .rstN(rstN),
    .d({diode_anode_in, diode_cathode_in}),
    .q({anodeSync, cathodeSync})
  );

  // Fault state of the six remote diodes
  logic [5:0] fault_r;
  logic [5:0] fault_nxt;

  // Anode high means open pair or anode on supply; open cathode also floats high
  always_comb begin
    fault_nxt = anodeSync | cathodeSync;
  end

  // Register the fault state
  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      fault_r <= 6'h00;
    end else begin
      fault_r <= fault_nxt;
    end
  end
  assign diodeFault = fault_r;

  // Measurement sequencer
  tasf_seq_t seq_r;
  tasf_seq_t seq_nxt;
  tasf_chan_t chan_r;
  tasf_chan_t chan_nxt;
  logic convTaken;

  // Pick a healthy channel, start it, wait for its result
  always_comb begin
    seq_nxt = seq_r;
    chan_nxt = chan_r;
    convTaken = 1'b0;
    case (seq_r)
      TASF_SEQ_PICK: begin
        chan_nxt = nextHealthy(chan_r, fault_r);
        seq_nxt = TASF_SEQ_START;
      end
      TASF_SEQ_START: begin
        seq_nxt = TASF_SEQ_WAIT;
      end
      TASF_SEQ_WAIT: begin
        if (convDone) begin
          convTaken = 1'b1;
          seq_nxt = TASF_SEQ_PICK;
        end
      end
      default: begin
        seq_nxt = TASF_SEQ_PICK;
      end
    endcase
  end

  // Register the sequencer; starts on channel 6 so local goes first
  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      seq_r <= TASF_SEQ_PICK;
      chan_r <= `TASF_CHAN_LAST;
    end else begin
      seq_r <= seq_nxt;
      chan_r <= chan_nxt;
    end
  end
  assign convStart = (seq_r == TASF_SEQ_START);
  assign convChan = chan_r;

  // Host read request crossing into the system domain
  logic reqTogSync;
  logic reqSeen_r;
  logic reqSeen_nxt;
  logic reqEvt;
  logic linkReqTog_r;
  logic linkSel_r;
  logic selSync;

  tasf_sync #(.WIDTH(1)) uReqSync (
    .clk(clk_sys),
    .rstN(rstN),
    .d(linkReqTog_r),
    .q(reqTogSync)
  );
  // Select holds from the take until the answer, so it has settled when the toggle lands
  assign selSync = linkSel_r;

  // Toggle edge marks one read request
  always_comb begin
    reqEvt = (reqTogSync != reqSeen_r);
    reqSeen_nxt = reqTogSync;
  end

  // Trip state and sticky flags
  logic [6:0] warnTrip_r;
  logic [6:0] warnTrip_nxt;
  logic [3:0] overTrip_r;
  logic [3:0] overTrip_nxt;
  logic [3:0] overFlag_r;
  logic [3:0] overFlag_nxt;
  logic [6:0] alertLatch_r;
  logic [6:0] alertLatch_nxt;
  logic [2:0] bitIdx;
  logic [2:0] slot;
  logic overRead;

  // Compare each finished conversion against its limits
  always_comb begin
    warnTrip_nxt = warnTrip_r;
    overTrip_nxt = overTrip_r;
    overFlag_nxt = overFlag_r;
    alertLatch_nxt = alertLatch_r;
    bitIdx = flagBit(chan_r);
    slot = overSlot(chan_r);
    overRead = reqEvt && (selSync == `TASF_SEL_OVER);
    // Clear on read comes first so a same-cycle set wins
    if (overRead) begin
      overFlag_nxt = `TASF_OVER_RST;
    end
    // Acknowledge drops the warning output, not the trip
    if (alertAck) begin
      alertLatch_nxt = `TASF_WARN_RST;
    end
    if (convTaken) begin
      if (convTemp > warnLimit[bitIdx]) begin
        warnTrip_nxt[bitIdx] = 1'b1;
      end else if (tripRelease(convTemp, warnLimit[bitIdx])) begin
        warnTrip_nxt[bitIdx] = 1'b0;
      end
      if (slot[2]) begin
        if (convTemp > overLimit[slot[1:0]]) begin
          overTrip_nxt[slot[1:0]] = 1'b1;
        end else if (tripRelease(convTemp, overLimit[slot[1:0]])) begin
          overTrip_nxt[slot[1:0]] = 1'b0;
        end
        if (overTrip_nxt[slot[1:0]]) begin
          overFlag_nxt[slot[1:0]] = 1'b1;
        end
      end
      // A standing trip rearms the warning output at conversion end
      if (warnTrip_nxt[bitIdx]) begin
        alertLatch_nxt[bitIdx] = 1'b1;
      end
    end
  end

  // Register trips, flags and the read edge tracker
  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      warnTrip_r <= `TASF_WARN_RST;
      overTrip_r <= `TASF_OVER_RST;
      overFlag_r <= `TASF_OVER_RST;
      alertLatch_r <= `TASF_WARN_RST;
      reqSeen_r <= 1'b0;
    end else begin
      warnTrip_r <= warnTrip_nxt;
      overTrip_r <= overTrip_nxt;
      overFlag_r <= overFlag_nxt;
      alertLatch_r <= alertLatch_nxt;
      reqSeen_r <= reqSeen_nxt;
    end
  end

  // Status views; a faulted diode shows as a set warning bit
  tasf_byte_t warnStatus;
  tasf_byte_t overStatus;
  assign warnStatus = {1'b0, warnTrip_r[6], warnTrip_r[5:0] | fault_r};
  assign overStatus = {2'h0, overFlag_r[3:1], 2'h0, overFlag_r[0]};

  // Output drive, open-drain low while enabled
  logic alertDrive_r;
  logic alertDrive_nxt;
  logic overDrive_r;
  logic overDrive_nxt;

  // Masked channels cannot pull the outputs
  always_comb begin
    alertDrive_nxt = |(alertLatch_r & ~warnMask);
    overDrive_nxt = |(overTrip_r & ~overMask);
  end

  // Register the output enables
  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      alertDrive_r <= 1'b0;
      overDrive_r <= 1'b0;
    end else begin
      alertDrive_r <= alertDrive_nxt;
      overDrive_r <= overDrive_nxt;
    end
  end
  assign alertOut = 1'b0;
  assign alertOutOe = alertDrive_r;
  assign overtemp_out = 1'b0;
  assign overtempOutOe = overDrive_r;

  // Read answer held for the link domain
  tasf_byte_t readData_r;
  tasf_byte_t readData_nxt;
  logic ackTog_r;
  logic ackTog_nxt;

  // Snapshot the selected register and toggle the acknowledge
  always_comb begin
    readData_nxt = readData_r;
    ackTog_nxt = ackTog_r;
    if (reqEvt) begin
      readData_nxt = (selSync == `TASF_SEL_OVER) ? overStatus : warnStatus;
      ackTog_nxt = ~ackTog_r;
    end
  end

  // Register the answer
  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      readData_r <= `TASF_BYTE_RST;
      ackTog_r <= 1'b0;
    end else begin
      readData_r <= readData_nxt;
      ackTog_r <= ackTog_nxt;
    end
  end

  // Reset synchroniser, link domain
  logic [1:0] linkRstPipe_r;
  logic linkRstN;

  // Release the link reset through two flip-flops
  always_ff @(posedge linkClk or negedge nrst) begin
    if (!nrst) begin
      linkRstPipe_r <= 2'h0;
    end else begin
      linkRstPipe_r <= {linkRstPipe_r[0], 1'b1};
    end
  end
  assign linkRstN = linkRstPipe_r[1];

  // Acknowledge crossing into the link domain
  logic ackSync;

  tasf_sync #(.WIDTH(1)) uAckSync (
    .clk(linkClk),
    .rstN(linkRstN),
    .d(ackTog_r),
    .q(ackSync)
  );

  // Link side request state
  logic linkReqTog_nxt;
  logic linkSel_nxt;
  logic linkPend_r;
  logic linkPend_nxt;
  logic ackSeen_r;
  logic ackSeen_nxt;
  tasf_byte_t linkData_r;
  tasf_byte_t linkData_nxt;
  logic linkValid_r;
  logic linkValid_nxt;

  // One read in flight; requests while busy are ignored
  always_comb begin
    linkReqTog_nxt = linkReqTog_r;
    linkSel_nxt = linkSel_r;
    linkPend_nxt = linkPend_r;
    ackSeen_nxt = ackSync;
    linkData_nxt = linkData_r;
    linkValid_nxt = 1'b0;
    if (linkReadReq && !linkPend_r) begin
      linkReqTog_nxt = ~linkReqTog_r;
      linkSel_nxt = linkRegSel;
      linkPend_nxt = 1'b1;
    end
    // Answer is stable in the system domain once the toggle arrives
    if (ackSync != ackSeen_r) begin
      linkData_nxt = readData_r;
      linkValid_nxt = 1'b1;
      linkPend_nxt = 1'b0;
    end
  end

  // Register the link side
  always_ff @(posedge linkClk or negedge linkRstN) begin
    if (!linkRstN) begin
      linkReqTog_r <= 1'b0;
      linkSel_r <= `TASF_SEL_WARN;
      linkPend_r <= 1'b0;
      ackSeen_r <= 1'b0;
      linkData_r <= `TASF_BYTE_RST;
      linkValid_r <= 1'b0;
    end else begin
      linkReqTog_r <= linkReqTog_nxt;
      linkSel_r <= linkSel_nxt;
      linkPend_r <= linkPend_nxt;
      ackSeen_r <= ackSeen_nxt;
      linkData_r <= linkData_nxt;
      linkValid_r <= linkValid_nxt;
    end
  end
  assign linkReadData = linkData_r;
  assign linkReadValid = linkValid_r;
  assign linkBusy = linkPend_r;

endmodule : tasf_status_flags

// ===== bench/tasf_status_flags_monitor.sv
// Port-level checker for the status flag block
module tasf_status_flags_monitor (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic convStart,
  input wire tasf_pkg::tasf_chan_t convChan,
  input wire logic convDone,
  input wire logic [5:0] diodeFault,
  input wire logic [3:0] overMask,
  input wire logic alertOut,
  input wire logic overtemp_out,
  input wire logic overtempOutOe,
  input wire logic linkClk,
  input wire logic linkReadReq,
  input wire logic linkBusy,
  input wire logic linkReadValid,
  input wire tasf_pkg::tasf_byte_t linkReadData
);
  import tasf_pkg::*;
  // Next start two cycles after a finished conversion
  sequence s_next_start;
    ##2 convStart;
  endsequence
  // A read request accepted by an idle port
  sequence s_take;
    linkReadReq && !linkBusy;
  endsequence
  property p_restart;
    @(posedge clk_sys) disable iff (!nrst) convDone |-> s_next_start;
  endproperty
  a_restart: assert property (p_restart) else $error("no start after conversion");
  property p_start_pulse;
    @(posedge clk_sys) disable iff (!nrst) convStart |=> !convStart;
  endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("start too long");
  property p_skip;
    // Judged against the fault state that the pick cycle saw
    @(posedge clk_sys) disable iff (!nrst) convStart && convChan != 3'h0 |->
      (($past(diodeFault) >> (convChan - 3'h1)) & 6'h01) == 6'h00;
  endproperty
  a_skip: assert property (p_skip) else $error("faulted channel converted");
  property p_oe_rise;
    // Pin rises after a conversion, or when a mask is lifted
    @(posedge clk_sys) disable iff (!nrst) $rose(overtempOutOe) |-> $past(convDone, 2) || $past(overMask, 2) != 4'h0;
  endproperty
  a_oe_rise: assert property (p_oe_rise) else $error("overtemp pin without conversion");
  property p_od_low;
    @(posedge clk_sys) disable iff (!nrst) alertOut == 1'b0 && overtemp_out == 1'b0;
  endproperty
  a_od_low: assert property (p_od_low) else $error("open drain data not low");
  property p_busy;
    @(posedge linkClk) disable iff (!nrst) s_take |=> linkBusy;
  endproperty
  a_busy: assert property (p_busy) else $error("read not taken");
  property p_answer;
    @(posedge linkClk) disable iff (!nrst) s_take |-> ##[1:60] linkReadValid;
  endproperty
  a_answer: assert property (p_answer) else $error("read never answered");
  property p_valid_pulse;
    @(posedge linkClk) disable iff (!nrst) linkReadValid |=> !linkReadValid && !linkBusy;
  endproperty
  a_valid_pulse: assert property (p_valid_pulse) else $error("valid not one cycle");
  property p_hold;
    @(posedge linkClk) disable iff (!nrst) !linkReadValid |-> $stable(linkReadData);
  endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
endmodule : tasf_status_flags_monitor

// ===== bench/tasf_host_model.sv
// Host side of the read port, one byte per request
module tasf_host_model (
  input wire logic linkClk,
  input wire logic linkBusy,
  input wire logic linkReadValid,
  input wire tasf_pkg::tasf_byte_t linkReadData,
  output logic linkReadReq,
  output logic linkRegSel
);
  timeunit 1ns;
  timeprecision 100ps;
  import tasf_pkg::*;
  initial begin
    linkReadReq = 1'b0;
    linkRegSel = 1'b0;
  end
  // Waits for an idle port, requests, then takes data at the valid edge
  task automatic rd(input logic sel, output tasf_byte_t d);
    int n;
    n = 0;
    @(posedge linkClk);
    while (linkBusy !== 1'b0) @(posedge linkClk);
    linkReadReq <= 1'b1;
    linkRegSel <= sel;
    @(posedge linkClk);
    // Select no longer qualified, so show its inverse
    linkReadReq <= 1'b0;
    linkRegSel <= ~sel;
    do begin
      @(posedge linkClk);
      n++;
    end while (linkReadValid !== 1'b1 && n < 60);
    // A read that never answers hands back unknowns, which no compare accepts
    d = (linkReadValid === 1'b1) ? linkReadData : 8'hxx;
  endtask : rd
endmodule : tasf_host_model

// ===== bench/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import tasf_pkg::*;
  logic clk_sys = 1'b0;
  logic linkClk = 1'b0;
  logic nrst = 1'b0;
  logic convDone = 1'b0;
  logic [7:0] convTemp = 8'h00;
  logic [6:0][7:0] warnLimit = {7{8'h64}};
  logic [3:0][7:0] overLimit = {4{8'h78}};
  logic [6:0] warnMask = 7'h00;
  logic [3:0] overMask = 4'h0;
  logic alertAck = 1'b0;
  logic [5:0] anodeIn = 6'h00;
  logic [5:0] cathodeIn = 6'h00;
  logic convStart, alertOut, alertOutOe, overtemp_out, overtempOutOe;
  logic linkReadReq, linkRegSel, linkReadValid, linkBusy;
  tasf_chan_t convChan;
  tasf_byte_t linkReadData, rdData;
  logic [5:0] diodeFault;
  logic [7:0] temps [7] = '{default: 8'h19}; // Converter result per channel
  logic [2:0] pend = 3'h0;
  int errors = 0;
  int tests_run = 0;
  int cyc = 0;
  int hits = 0; // Starts of channels 3 and 5
  always #50 clk_sys = ~clk_sys;
  always #3 linkClk = ~linkClk;
  tasf_status_flags DUT (.clk_sys(clk_sys), .nrst(nrst), .convStart(convStart), .convChan(convChan),
    .convDone(convDone), .convTemp(convTemp), .warnLimit(warnLimit), .overLimit(overLimit),
    .warnMask(warnMask), .overMask(overMask), .alertAck(alertAck), .diode_anode_in(anodeIn),
    .diode_cathode_in(cathodeIn), .diodeFault(diodeFault), .alertOut(alertOut), .alertOutOe(alertOutOe),
    .overtemp_out(overtemp_out), .overtempOutOe(overtempOutOe), .linkClk(linkClk),
    .linkReadReq(linkReadReq), .linkRegSel(linkRegSel), .linkReadData(linkReadData),
    .linkReadValid(linkReadValid), .linkBusy(linkBusy));
  tasf_host_model host (.linkClk(linkClk), .linkBusy(linkBusy), .linkReadValid(linkReadValid),
    .linkReadData(linkReadData), .linkReadReq(linkReadReq), .linkRegSel(linkRegSel));
  // Converter answers four cycles after each start; result lines toggle otherwise
  always @(posedge clk_sys) begin
    convDone <= 1'b0;
    convTemp <= ~convTemp;
    if (convStart === 1'b1) begin
      pend <= 3'h4;
    end else if (pend != 3'h0) begin
      pend <= pend - 3'h1;
      if (pend == 3'h1) begin
        convDone <= 1'b1;
        convTemp <= temps[convChan];
      end
    end
    if (convStart === 1'b1 && (convChan === 3'h3 || convChan === 3'h5)) hits <= hits + 1;
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      errors = errors + 1;
      give_verdict();
    end
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Waits for n local conversions plus settling
  task automatic sweep(input int n);
    int k;
    k = 0;
    while (k < n) begin
      @(posedge clk_sys);
      if (convDone === 1'b1 && convChan === 3'h0) k++;
    end
    repeat (3) @(posedge clk_sys);
  endtask : sweep
  task automatic t_reset;
    repeat (2) @(posedge clk_sys);
    host.rd(1'b0, rdData);
    chk(rdData, 8'h00);
    host.rd(1'b1, rdData);
    chk(rdData, 8'h00);
    chk({7'h00, overtempOutOe}, 8'h00);
    $display("test reset finished");
  endtask : t_reset
  task automatic t_warn;
    for (int ch = 0; ch < 7; ch++) begin
      temps[ch] <= 8'h65;
      sweep(2);
      host.rd(1'b0, rdData);
      chk(rdData, 8'h01 << ((ch == 0) ? 6 : ch - 1));
      temps[ch] <= 8'h19;
    end
    $display("test warn finished");
  endtask : t_warn
  task automatic t_hyst;
    logic [7:0] tv [3];
    logic [7:0] ex [3];
    tv = '{8'h65, 8'h61, 8'h60};
    ex = '{8'h20, 8'h20, 8'h00};
    temps[1] <= 8'h64;
    for (int i = 0; i < 3; i++) begin
      temps[6] <= tv[i];
      sweep(2);
      host.rd(1'b0, rdData);
      chk(rdData, ex[i]);
    end
    temps[1] <= 8'h19;
    $display("test hysteresis finished");
  endtask : t_hyst
  task automatic t_alert;
    temps[2] <= 8'h65;
    sweep(2);
    chk({7'h00, alertOutOe}, 8'h01);
    @(posedge clk_sys);
    alertAck <= 1'b1;
    @(posedge clk_sys);
    alertAck <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk({7'h00, alertOutOe}, 8'h00);
    sweep(1);
    chk({7'h00, alertOutOe}, 8'h01);
    warnMask <= 7'h02;
    repeat (3) @(posedge clk_sys);
    chk({7'h00, alertOutOe}, 8'h00);
    warnMask <= 7'h00;
    temps[2] <= 8'h19;
    $display("test alert finished");
  endtask : t_alert
  task automatic t_over;
    for (int c = 1; c < 7; c++) if (c == 1 || c > 3) temps[c] <= 8'h79;
    sweep(2);
    host.rd(1'b1, rdData);
    chk(rdData, 8'h39);
    chk({7'h00, overtempOutOe}, 8'h01);
    // Hot sweep after the read sets every flag again
    sweep(1);
    overMask <= 4'hf;
    repeat (3) @(posedge clk_sys);
    chk({7'h00, overtempOutOe}, 8'h00);
    overMask <= 4'h0;
    for (int c = 1; c < 7; c++) temps[c] <= 8'h19;
    sweep(2);
    chk({7'h00, overtempOutOe}, 8'h00);
    host.rd(1'b1, rdData);
    chk(rdData, 8'h39);
    host.rd(1'b1, rdData);
    chk(rdData, 8'h00);
    $display("test overtemp finished");
  endtask : t_over
  task automatic t_fault;
    anodeIn <= 6'h04;
    cathodeIn <= 6'h10;
    sweep(2);
    hits = 0;
    sweep(2);
    chk(hits[7:0], 8'h00);
    chk({2'h0, diodeFault}, 8'h14);
    host.rd(1'b0, rdData);
    chk(rdData, 8'h14);
    anodeIn <= 6'h00;
    cathodeIn <= 6'h00;
    sweep(2);
    hits = 0;
    sweep(1);
    chk(hits[7:0], 8'h02);
    chk({2'h0, diodeFault}, 8'h00);
    $display("test fault finished");
  endtask : t_fault
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : give_verdict
  initial begin
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    t_reset();
    t_warn();
    t_hyst();
    t_alert();
    t_over();
    t_fault();
    give_verdict();
  end
endmodule : tb_top
bind tasf_status_flags tasf_status_flags_monitor u_mon (.clk_sys(clk_sys), .nrst(nrst), .convStart(convStart),
  .convChan(convChan), .convDone(convDone), .diodeFault(diodeFault), .overMask(overMask), .alertOut(alertOut),
  .overtemp_out(overtemp_out), .overtempOutOe(overtempOutOe), .linkClk(linkClk), .linkReadReq(linkReadReq),
  .linkBusy(linkBusy), .linkReadValid(linkReadValid), .linkReadData(linkReadData));
